//--- ovfw_host_model.sv
// Host model driving the link-domain command port
`timescale 1ns/1ns
module ovfw_host_model (
	input wire logic link_clk_in,
	input wire logic [15:0] cmd_rdata_in,
	input wire logic cmd_rvalid_in,
	output logic [7:0] cmd_code_out,
	output logic cmd_write_out,
	output logic cmd_read_out,
	output logic cmd_word_out,
	output logic [15:0] cmd_wdata_out
);
	initial begin
		cmd_code_out = 8'h00;
		cmd_write_out = 1'b0;
		cmd_read_out = 1'b0;
		cmd_word_out = 1'b0;
		cmd_wdata_out = 16'h0000;
	end
	////////////////////////////////////////////////////////////////
	// Released lines flip so a stale copy is never mistaken for data
	task automatic release_bus();
		cmd_code_out = ~cmd_code_out;
		cmd_word_out = ~cmd_word_out;
		cmd_wdata_out = ~cmd_wdata_out;
	endtask : release_bus
	// Width flag travels with the strobe
	task automatic wr(input logic [7:0] code, input logic word, input logic [15:0] data);
		@(posedge link_clk_in);
		#5;
		cmd_code_out = code;
		cmd_word_out = word;
		cmd_wdata_out = data;
		cmd_write_out = 1'b1;
		@(posedge link_clk_in);
		#5;
		cmd_write_out = 1'b0;
		// Data held until the core has sampled it
		repeat (8) @(posedge link_clk_in);
		#5;
		release_bus();
	endtask : wr
	task automatic rd(input logic [7:0] code, output logic [15:0] data);
		@(posedge link_clk_in);
		#5;
		cmd_code_out = code;
		cmd_read_out = 1'b1;
		@(posedge link_clk_in);
		#5;
		cmd_read_out = 1'b0;
		release_bus();
		for (int i = 0; i < 3 && cmd_rvalid_in !== 1'b1; i++) begin
			@(posedge link_clk_in);
			#5;
		end
		data = (cmd_rvalid_in === 1'b1) ? cmd_rdata_in : 16'hXXXX;
	endtask : rd
endmodule : ovfw_host_model

//--- ovfw_pct_map.sv
// Maps a written warning limit word onto the supported percentage steps
`timescale 1ns/1ns
module ovfw_pct_map (
	input wire logic [15:0] value_in,
	input wire logic abs_mode_in,
	input wire logic [15:0] target_in,
	output logic [3:0] pct_idx_out,
	output logic invalid_out
);
	import ovfw_pkg::*;

	wire [15:0] base = abs_mode_in ? target_in : REL_UNITY;
	wire [23:0] scaled_value = 24'(value_in) * PCT_SCALE;
	logic [PCT_N-1:0] above;

	// Thermometer of steps that the limit exceeds; counting them rounds upward
	genvar gi;
	generate
		for (gi = 0; gi < PCT_N; gi++) begin : g_step
			assign above[gi] = scaled_value > 24'(base) * 24'(PCT_MIN + gi);
		end
	endgenerate

	always_comb begin
		pct_idx_out = 4'h0;
		for (int i = 0; i < PCT_N - 1; i++) begin
			pct_idx_out = pct_idx_out + 4'(above[i]);
		end
	end

	// Beyond the highest step there is nothing to round up to
	assign invalid_out = above[PCT_N-1];

endmodule : ovfw_pct_map

//--- ovfw_pkg.sv
// Constants, field layouts and state encoding for the overvoltage response and warning block
package ovfw_pkg;

	// Command codes of the two configuration commands
	localparam logic [7:0] CMD_RESPONSE = 8'h41;
	localparam logic [7:0] CMD_WARN_LIMIT = 8'h42;

	// Response byte field positions
	localparam int ACTION_MSB = 7;
	localparam int ACTION_LSB = 6;
	localparam int RETRY_MSB = 5;
	localparam int RETRY_LSB = 3;
	localparam int DELAY_MSB = 2;
	localparam int DELAY_LSB = 0;

	// Action and retry encodings
	localparam logic [1:0] ACTION_IGNORE = 2'h0;
	localparam logic [1:0] ACTION_BAD = 2'h3;
	localparam logic [2:0] RETRY_LATCH = 3'h0;
	localparam logic [2:0] RETRY_FOREVER = 3'h7;
	localparam logic [2:0] DELAY_SINGLE = 3'h0;

	// Warning threshold percentages supported by hardware
	localparam int PCT_MIN = 103;
	localparam int PCT_MAX = 116;
	localparam int PCT_N = PCT_MAX - PCT_MIN + 1;
	localparam logic [3:0] PCT_LAST = 4'hD;
	localparam logic [23:0] PCT_SCALE = 24'h000064;
	// Unity ratio of a relative-format limit word
	localparam logic [15:0] REL_UNITY = 16'h0200;

	// Reset contents standing in for nonvolatile defaults
	localparam logic [7:0] NVM_RESPONSE = 8'h80;
	// Reset limit word must round to the reset step, or read-back and compare disagree
	localparam logic [15:0] NVM_WARN_LIMIT = 16'h0228;
	localparam logic [3:0] NVM_WARN_PCT = 4'h5;

	// Timing
	localparam int CLK_MHZ = 10;
	localparam int TON_RISE_US = 1000;
	localparam int TON_MAX_US = 5000;
	localparam int RISE_CYC_DEF = TON_RISE_US * CLK_MHZ;
	localparam int TONMAX_CYC_DEF = TON_MAX_US * CLK_MHZ;
	localparam int TMR_W = 20;

	// Power sequencing states, Gray coded along off-rise-quiet-on-hiccup-latch
	typedef enum logic [2:0] {
		ST_OFF = 3'h0,
		ST_RISE = 3'h1,
		ST_QUIET = 3'h3,
		ST_ON = 3'h2,
		ST_HICCUP = 3'h6,
		ST_LATCH = 3'h7
	} ovfw_state_t;

endpackage : ovfw_pkg

//--- ovfw_top.sv
// Output overvoltage fault response, hiccup retry and overvoltage warning logic
//
// How it works
// - On a fault pulse the status byte, status word and output status flags and alert are all set in the same cycle.
// - Action 00 ignores the fault, 01 and 10 shut down, 11 is rejected.
// - Retry value 0 latches off at the first shutdown.
// - Retry 1 to 6 waits a hiccup before each attempt, then latches off.
// - Retry 7 keeps hiccuping and retrying until disabled or started.
// - Hiccup period is one rise time for delay 0, else delay rise times.
// - Quiet rise time after rise, or after start timeout, clears the attempt count.
// - A fault present at enable blocks start-up, even when ignoring.
// - Unsupported writes to either command are dropped and flagged as invalid; an out-of-range limit word is still kept for read-back.
// - Sensed voltage rising over the warning limit flags status and alerts.
// - Warning limit kept as percentage of target, converted per output mode.
// - Written limit rounds up to 103..116 percent in one percent steps.
// - Warning limit is a word transfer, response a byte transfer.
// - Response byte loads defaults at reset and acts at once when written.
`timescale 1ns/1ns
module ovfw_top #(
	parameter int RISE_CYC = ovfw_pkg::RISE_CYC_DEF,
	parameter int TONMAX_CYC = ovfw_pkg::TONMAX_CYC_DEF
) (
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic link_clk_in,
	input wire logic [7:0] cmd_code_in,
	input wire logic cmd_write_in,
	input wire logic cmd_read_in,
	input wire logic cmd_word_in,
	input wire logic [15:0] cmd_wdata_in,
	output logic [15:0] cmd_rdata_out,
	output logic cmd_rvalid_out,
	input wire logic ov_fault_in,
	input wire logic enable_in,
	input wire logic [15:0] vout_sense_in,
	input wire logic [15:0] vout_target_in,
	input wire logic abs_mode_in,
	input wire logic ton_max_enabled_in,
	output logic output_enable_out,
	output logic latched_off_out,
	output logic [2:0] restart_count_out,
	output logic status_byte_ov_set_out,
	output logic status_word_vout_set_out,
	output logic status_overvolt_fault_value_set_out,
	output logic status_overvolt_warning_value_set_out,
	output logic invalid_data_out,
	output logic host_alert_out
);
	import ovfw_pkg::*;

	localparam logic [TMR_W-1:0] RISE_LAST = TMR_W'(RISE_CYC - 1);
	localparam logic [TMR_W-1:0] TONMAX_LAST = TMR_W'(TONMAX_CYC - 1);

	////////////////////////////////////////////////////////////////////////////////
	// Reset release in both domains

	logic rst_s1, rst_n;
	logic lrst_s1, lrst_n;

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rst_s1 <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_s1 <= 1'b1;
			rst_n <= rst_s1;
		end
	end

	always_ff @(posedge link_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			lrst_s1 <= 1'b0;
			lrst_n <= 1'b0;
		end else begin
			lrst_s1 <= 1'b1;
			lrst_n <= lrst_s1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Link side: command capture and read-back

	logic [7:0] hold_code;
	logic hold_word;
	logic [15:0] hold_data;
	logic wr_tog;
	logic [7:0] resp_shadow;
	logic [15:0] warn_shadow;

	wire l_resp_ok = cmd_code_in == CMD_RESPONSE && !cmd_word_in
		&& cmd_wdata_in[ACTION_MSB:ACTION_LSB] != ACTION_BAD;
	wire l_warn_wr = cmd_code_in == CMD_WARN_LIMIT && cmd_word_in;
	wire [15:0] read_mux = (cmd_code_in == CMD_RESPONSE) ? {8'h00, resp_shadow} :
		(cmd_code_in == CMD_WARN_LIMIT) ? warn_shadow : 16'h0000;

	// Hold registers stay still until the next write, so the core may sample them after the toggle
	always_ff @(posedge link_clk_in or negedge lrst_n) begin
		if (!lrst_n) begin
			hold_code <= 8'h00;
			hold_word <= 1'b0;
			hold_data <= 16'h0000;
			wr_tog <= 1'b0;
		end else if (cmd_write_in) begin
			hold_code <= cmd_code_in;
			hold_word <= cmd_word_in;
			hold_data <= cmd_wdata_in;
			wr_tog <= !wr_tog;
		end
	end

	always_ff @(posedge link_clk_in or negedge lrst_n) begin
		if (!lrst_n) begin
			resp_shadow <= NVM_RESPONSE;
			warn_shadow <= NVM_WARN_LIMIT;
		end else if (cmd_write_in) begin
			if (l_resp_ok) resp_shadow <= cmd_wdata_in[7:0];
			if (l_warn_wr) warn_shadow <= cmd_wdata_in;
		end
	end

	always_ff @(posedge link_clk_in or negedge lrst_n) begin
		if (!lrst_n) begin
			cmd_rdata_out <= 16'h0000;
			cmd_rvalid_out <= 1'b0;
		end else begin
			cmd_rdata_out <= cmd_read_in ? read_mux : cmd_rdata_out;
			cmd_rvalid_out <= cmd_read_in;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Core side synchronisers

	logic tog_s1, tog_s2, tog_s3;
	logic fault_s1, fault_s, fault_d;
	logic en_s1, en_s;

	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			tog_s1 <= 1'b0;
			tog_s2 <= 1'b0;
			tog_s3 <= 1'b0;
			fault_s1 <= 1'b0;
			fault_s <= 1'b0;
			fault_d <= 1'b0;
			en_s1 <= 1'b0;
			en_s <= 1'b0;
		end else begin
			tog_s1 <= wr_tog;
			tog_s2 <= tog_s1;
			tog_s3 <= tog_s2;
			fault_s1 <= ov_fault_in;
			fault_s <= fault_s1;
			fault_d <= fault_s;
			en_s1 <= enable_in;
			en_s <= en_s1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Core configuration registers

	logic [7:0] cfg_resp;
	logic [3:0] warn_pct;
	logic [3:0] map_idx;
	logic map_invalid;

	ovfw_pct_map u_map (
		.value_in(hold_data),
		.abs_mode_in(abs_mode_in),
		.target_in(vout_target_in),
		.pct_idx_out(map_idx),
		.invalid_out(map_invalid)
	);

	wire wr_event = tog_s2 ^ tog_s3;
	wire is_resp = hold_code == CMD_RESPONSE;
	wire is_warn = hold_code == CMD_WARN_LIMIT;
	wire resp_ok = is_resp && !hold_word
		&& hold_data[ACTION_MSB:ACTION_LSB] != ACTION_BAD;
	wire warn_ok = is_warn && hold_word && !map_invalid;
	wire bad_write = wr_event && (is_resp || is_warn) && !(resp_ok || warn_ok);

	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			cfg_resp <= NVM_RESPONSE;
			warn_pct <= NVM_WARN_PCT;
		end else if (wr_event) begin
			if (resp_ok) cfg_resp <= hold_data[7:0];
			if (warn_ok) warn_pct <= map_idx;
		end
	end

	wire [1:0] action = cfg_resp[ACTION_MSB:ACTION_LSB];
	wire [2:0] retry = cfg_resp[RETRY_MSB:RETRY_LSB];
	wire [2:0] delay = cfg_resp[DELAY_MSB:DELAY_LSB];
	wire [2:0] mult_last = (delay == DELAY_SINGLE) ? 3'h0 : delay - 3'h1;

	////////////////////////////////////////////////////////////////////////////////
	// Power sequencing

	ovfw_state_t state, next_state;
	logic [TMR_W-1:0] tmr;
	logic [2:0] mult_cnt;
	logic [2:0] count, next_count;

	wire shut = fault_s && action != ACTION_IGNORE
		&& (state == ST_RISE || state == ST_QUIET || state == ST_ON);
	wire rise_done = tmr == (ton_max_enabled_in ? TONMAX_LAST : RISE_LAST);
	wire period_done = tmr == RISE_LAST;
	wire hiccup_done = period_done && mult_cnt == mult_last;
	wire may_retry = retry == RETRY_FOREVER || count < retry;

	always_comb begin
		next_state = state;
		next_count = count;
		if (!en_s) begin
			next_state = ST_OFF;
			next_count = 3'h0;
		end else if (shut) begin
			if (retry == RETRY_LATCH || !may_retry) begin
				next_state = ST_LATCH;
			end else begin
				next_state = ST_HICCUP;
				next_count = (count == RETRY_FOREVER) ? count : count + 3'h1;
			end
		end else begin
			case (state)
				ST_OFF: next_state = fault_s ? ST_OFF : ST_RISE;
				ST_RISE: next_state = rise_done ? ST_QUIET : ST_RISE;
				ST_QUIET: begin
					if (period_done) begin
						next_state = ST_ON;
						next_count = 3'h0;
					end
				end
				ST_ON: next_state = ST_ON;
				ST_HICCUP: next_state = hiccup_done ? ST_RISE : ST_HICCUP;
				ST_LATCH: next_state = ST_LATCH;
				default: next_state = ST_OFF;
			endcase
		end
	end

	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_OFF;
			count <= 3'h0;
		end else begin
			state <= next_state;
			count <= next_count;
		end
	end

	// One timer serves rise, quiet and hiccup; it restarts on every state change
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			tmr <= '0;
			mult_cnt <= 3'h0;
		end else if (next_state != state) begin
			tmr <= '0;
			mult_cnt <= 3'h0;
		end else if (state == ST_HICCUP && period_done) begin
			tmr <= '0;
			mult_cnt <= mult_cnt + 3'h1;
		end else begin
			tmr <= tmr + TMR_W'(1);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Warning compare and status events

	wire [23:0] sense_scaled = 24'(vout_sense_in) * PCT_SCALE;
	wire [23:0] warn_level = 24'(vout_target_in) * (24'(PCT_MIN) + 24'(warn_pct));
	wire warn_over = sense_scaled > warn_level;
	logic warn_d;
	wire warn_rise = warn_over && !warn_d;
	wire fault_rise = fault_s && !fault_d;

	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			warn_d <= 1'b0;
			output_enable_out <= 1'b0;
			latched_off_out <= 1'b0;
			restart_count_out <= 3'h0;
			status_byte_ov_set_out <= 1'b0;
			status_word_vout_set_out <= 1'b0;
			status_overvolt_fault_value_set_out <= 1'b0;
			status_overvolt_warning_value_set_out <= 1'b0;
			invalid_data_out <= 1'b0;
			host_alert_out <= 1'b0;
		end else begin
			warn_d <= warn_over;
			output_enable_out <= next_state == ST_RISE || next_state == ST_QUIET
				|| next_state == ST_ON;
			latched_off_out <= next_state == ST_LATCH;
			restart_count_out <= next_count;
			status_byte_ov_set_out <= fault_rise;
			status_overvolt_fault_value_set_out <= fault_rise;
			status_word_vout_set_out <= fault_rise || warn_rise;
			status_overvolt_warning_value_set_out <= warn_rise;
			invalid_data_out <= bad_write;
			host_alert_out <= fault_rise || warn_rise || bad_write;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n);

	sequence s_shutdown_latch;
		shut && en_s && (retry == RETRY_LATCH || (retry != RETRY_FOREVER && count >= retry));
	endsequence

	sequence s_quiet_pass;
		en_s && !shut && state == ST_QUIET && period_done;
	endsequence

	a_fault_flags: assert property (fault_rise |=> status_byte_ov_set_out
		&& status_overvolt_fault_value_set_out && status_word_vout_set_out && host_alert_out)
		else $error("fault flags not raised");
	a_ignore_runs: assert property (state == ST_ON && en_s && action == ACTION_IGNORE
		|=> state == ST_ON) else $error("ignored fault left regulation");
	a_bad_action: assert property (wr_event && is_resp && hold_data[7:6] == ACTION_BAD
		|=> $stable(cfg_resp) ##0 invalid_data_out) else $error("bad action accepted");
	a_latch_off: assert property (s_shutdown_latch |=> latched_off_out
		&& !output_enable_out) else $error("no latch off");
	a_retry_step: assert property (shut && en_s && retry != RETRY_LATCH && may_retry
		|=> state == ST_HICCUP && !output_enable_out) else $error("no hiccup");
	a_hiccup_end: assert property (state == ST_HICCUP && en_s && hiccup_done
		|=> state == ST_RISE ##0 output_enable_out) else $error("hiccup end wrong");
	a_hiccup_len: assert property (state == ST_HICCUP |-> mult_cnt <= mult_last
		&& tmr <= RISE_LAST) else $error("hiccup overran");
	a_forever: assert property (shut && en_s && retry == RETRY_FOREVER
		|=> state == ST_HICCUP ##1 !latched_off_out) else $error("retry forever stopped");
	a_success: assert property (s_quiet_pass |=> state == ST_ON
		&& restart_count_out == 3'h0) else $error("start not counted as success");
	a_start_block: assert property (state == ST_OFF && en_s && fault_s
		|=> state == ST_OFF && !output_enable_out) else $error("started into a fault");
	a_warn_flags: assert property (warn_rise |=> status_overvolt_warning_value_set_out
		&& status_word_vout_set_out && host_alert_out) else $error("warn flags not raised");
	a_pct_range: assert property (warn_pct <= PCT_LAST)
		else $error("warning step out of range");
	a_latch_hold: assert property (state == ST_LATCH && en_s
		|=> state == ST_LATCH) else $error("left latch while enabled");

endmodule : ovfw_top

//--- testbench.sv
// Self-checking bench for the overvoltage response and warning block
`timescale 1ns/1ns
module testbench;
	import ovfw_pkg::*;
	localparam int RISE = 20;
	localparam int TONMAX = 40;
	localparam logic [16:0] BADW [4] = '{17'h1_0052, 17'h0_0210, 17'h0_00C0, 17'h1_0252};
	logic clk_in = 1'b0;
	logic link_clk = 1'b0;
	logic reset_n = 1'b0;
	logic [7:0] code;
	logic wr_s, rd_s, word_s, rvalid;
	logic [15:0] wdata, rdata;
	logic fault = 1'b0;
	logic enable = 1'b0;
	logic [15:0] sense = 16'h0000;
	logic [15:0] target = 16'h03E8;
	logic abs_m = 1'b0;
	logic tmax = 1'b0;
	logic oe, latched;
	logic [2:0] rcount;
	wire [5:0] pl;
	int cnt [6];
	int base [6];
	int bad_count = 0;
	int compares = 0;
	int seed = 41998;
	always #50 clk_in = ~clk_in;
	initial begin
		#37;
		forever begin
			#62 link_clk = ~link_clk;
			#63 link_clk = ~link_clk;
		end
	end
	ovfw_host_model host (.link_clk_in(link_clk), .cmd_rdata_in(rdata), .cmd_rvalid_in(rvalid),
		.cmd_code_out(code), .cmd_write_out(wr_s), .cmd_read_out(rd_s), .cmd_word_out(word_s),
		.cmd_wdata_out(wdata));
	ovfw_top #(.RISE_CYC(RISE), .TONMAX_CYC(TONMAX)) uut (.clk_in(clk_in), .reset_n_in(reset_n),
		.link_clk_in(link_clk), .cmd_code_in(code), .cmd_write_in(wr_s), .cmd_read_in(rd_s),
		.cmd_word_in(word_s), .cmd_wdata_in(wdata), .cmd_rdata_out(rdata), .cmd_rvalid_out(rvalid),
		.ov_fault_in(fault), .enable_in(enable), .vout_sense_in(sense), .vout_target_in(target),
		.abs_mode_in(abs_m), .ton_max_enabled_in(tmax), .output_enable_out(oe),
		.latched_off_out(latched), .restart_count_out(rcount), .status_byte_ov_set_out(pl[0]),
		.status_word_vout_set_out(pl[1]), .status_overvolt_fault_value_set_out(pl[2]),
		.status_overvolt_warning_value_set_out(pl[3]), .invalid_data_out(pl[4]), .host_alert_out(pl[5]));
	// Counted mid-cycle, away from the edge that launches each pulse
	always @(negedge clk_in) begin
		for (int i = 0; i < 6; i++) begin
			if (pl[i] === 1'b1) cnt[i]++;
		end
	end
	////////////////////////////////////////////////////////////////
	function automatic int exp_pct(input int v, input bit abs_f);
		int b;
		b = abs_f ? int'(target) : int'(REL_UNITY);
		for (int p = PCT_MIN; p <= PCT_MAX; p++) begin
			if (v * 100 <= b * p) return p;
		end
		return 0;
	endfunction : exp_pct
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic pulses(input int b, input int w, input int f, input int v, input int i,
		input int a);
		int e [6];
		e = '{b, w, f, v, i, a};
		for (int k = 0; k < 6; k++) begin
			chk($sformatf("pulse count %0d", k), 16'(cnt[k] - base[k]), 16'(e[k]));
			base[k] = cnt[k];
		end
	endtask : pulses
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_in);
		#5;
	endtask : cyc
	task automatic wait_lvl(ref logic s, input logic v, input int n);
		for (int k = 0; k < n && s !== v; k++) cyc(1);
		chk("level wait", s, v);
	endtask : wait_lvl
	task automatic fpulse();
		fault = 1'b1;
		cyc(3);
		fault = 1'b0;
	endtask : fpulse
	// Equality must stay quiet, one count above must warn once
	task automatic warn_at(input int p);
		sense = 16'(10 * p);
		cyc(6);
		sense = 16'(10 * p + 1);
		cyc(6);
		sense = 16'h0000;
		cyc(4);
		pulses(0, 1, 0, 1, 0, 1);
	endtask : warn_at
	task automatic wrap_up();
		if (bad_count == 0 && compares > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : wrap_up
	initial begin
		#2000000;
		bad_count++;
		wrap_up();
	end
	////////////////////////////////////////////////////////////////
	initial begin
		logic [15:0] r;
		int v;
		int n;
		cyc(8);
		reset_n = 1'b1;
		repeat (4) @(posedge link_clk);
		host.rd(CMD_RESPONSE, r);
		chk("response reset", r, {8'h00, NVM_RESPONSE});
		host.rd(CMD_WARN_LIMIT, r);
		chk("limit reset", r, NVM_WARN_LIMIT);
		host.rd(8'h50, r);
		chk("unmapped read", r, 16'h0000);
		cyc(1);
		warn_at(exp_pct(int'(NVM_WARN_LIMIT), 1'b0));
		for (int k = 0; k < 4; k++) begin
			host.wr(k[0] ? CMD_WARN_LIMIT : CMD_RESPONSE, BADW[k][16], BADW[k][15:0]);
			cyc(4);
			pulses(0, 0, 0, 0, 1, 1);
		end
		host.rd(CMD_RESPONSE, r);
		chk("response kept", r, {8'h00, NVM_RESPONSE});
		cyc(1);
		warn_at(108);
		enable = 1'b1;
		wait_lvl(oe, 1'b1, 10);
		cyc(2 * RISE + 5);
		fpulse();
		wait_lvl(latched, 1'b1, 10);
		chk("shut down", oe, 1'b0);
		cyc(4);
		pulses(1, 1, 1, 0, 0, 1);
		cyc(100);
		chk("stays off", oe, 1'b0);
		enable = 1'b0;
		wait_lvl(latched, 1'b0, 10);
		for (int k = 0; k < 8; k++) begin
			abs_m = k[0];
			v = k[0] ? 960 + ($unsigned($random(seed)) % 201) : 480 + ($unsigned($random(seed)) % 114);
			v = (k == 0) ? 480 : (k == 1) ? 1160 : v;
			host.wr(CMD_WARN_LIMIT, 1'b1, 16'(v));
			host.rd(CMD_WARN_LIMIT, r);
			chk("limit readback", r, 16'(v));
			cyc(4);
			warn_at(exp_pct(v, k[0]));
		end
		abs_m = 1'b0;
		host.wr(CMD_RESPONSE, 1'b0, 16'h0052);
		cyc(4);
		enable = 1'b1;
		wait_lvl(oe, 1'b1, 10);
		cyc(2 * RISE + 5);
		for (int k = 1; k <= 3; k++) begin
			fpulse();
			if (k == 3) break;
			wait_lvl(oe, 1'b0, 10);
			n = 0;
			while (oe === 1'b0 && n < 100) begin
				cyc(1);
				n++;
			end
			chk("hiccup span", 16'(n >= 2 * RISE - 1 && n <= 2 * RISE + 2), 16'h0001);
			chk("attempts", rcount, 16'(k));
		end
		wait_lvl(latched, 1'b1, 10);
		chk("attempts at latch", rcount, 3'h2);
		enable = 1'b0;
		cyc(5);
		chk("count on disable", rcount, 3'h0);
		pulses(3, 3, 3, 0, 0, 3);
		host.wr(CMD_RESPONSE, 1'b0, 16'h0078);
		cyc(4);
		tmax = 1'b1;
		enable = 1'b1;
		for (int k = 1; k <= 8; k++) begin
			wait_lvl(oe, 1'b1, 2 * RISE + 10);
			fpulse();
			wait_lvl(oe, 1'b0, 10);
			chk("forever count", rcount, 16'((k > 7) ? 7 : k));
		end
		wait_lvl(oe, 1'b1, 2 * RISE + 10);
		cyc(TONMAX + 10);
		chk("count before quiet", rcount, 3'h7);
		cyc(RISE);
		chk("count cleared", rcount, 3'h0);
		chk("never latched", latched, 1'b0);
		host.wr(CMD_RESPONSE, 1'b0, 16'h0000);
		cyc(4);
		fpulse();
		cyc(30);
		chk("ignore keeps on", oe, 1'b1);
		pulses(9, 9, 9, 0, 0, 9);
		enable = 1'b0;
		cyc(5);
		fault = 1'b1;
		enable = 1'b1;
		cyc(3 * RISE);
		chk("blocked start", oe, 1'b0);
		fault = 1'b0;
		wait_lvl(oe, 1'b1, 10);
		wrap_up();
	end
endmodule : testbench
